// ===== hw/tcc_timer.sv
// 16-bit timer with two capture/compare registers and pulse output
`default_nettype none

module tcc_timer
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire tcc_axi_req_s axi_req,
  output tcc_axi_rsp_s axi_rsp,
  input wire logic trigger_input_a,
  input wire logic trigger_input_b,
  output logic timer_output_pin,
  output logic timer_output_en_n,
  output logic match_a_irq,
  output logic match_b_irq,
  output logic irq
);

  typedef struct packed {
    tcc_ctrl_s ctrl;
    tcc_edgec_s edgec;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cca;
    logic [CNT_W-1:0] ccb;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic [PRESC_W-1:0] presc_cnt;
    logic upd;
    logic tout;
    logic match_a;
    logic match_b;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcc_state_s;

  tcc_state_s st_reg;
  tcc_state_s st_next;

  logic edge_a;
  logic edge_b;
  logic tick;
  logic trig_b_used;
  logic a_cap_ev;
  logic b_cap_ev;
  logic aw_go;
  logic w_go;
  logic ar_go;
  logic do_write;
  logic wr_ok;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;

  // ********************************************************
  // trigger inputs
  // ********************************************************
  tcc_edge_sync u_sync_a (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(trigger_input_a),
    .edge_sel(st_reg.edgec.edge_a),
    .edge_pulse(edge_a)
  );

  tcc_edge_sync u_sync_b (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(trigger_input_b),
    .edge_sel(st_reg.edgec.edge_b),
    .edge_pulse(edge_b)
  );

  // ********************************************************
  // count clock and capture events
  // ********************************************************
  // count clock is core_clk divided by the prescaler select
  assign tick = st_reg.ctrl.mode != MODE_STOP &&
                st_reg.presc_cnt == tcc_presc_last(st_reg.edgec.presc);
  // trigger b edges only matter when a captures from it
  assign trig_b_used = st_reg.ctrl.a_capture & st_reg.ctrl.a_trig_sel;
  assign a_cap_ev = st_reg.ctrl.a_capture &
                    (st_reg.ctrl.a_trig_sel ? edge_b : edge_a);
  assign b_cap_ev = st_reg.ctrl.b_capture & edge_a;

  // ********************************************************
  // register decode
  // ********************************************************
  // handshake readies stall while a response is still pending
  assign aw_go = axi_req.awvalid & ~st_reg.aw_held & ~st_reg.bvalid;
  assign w_go = axi_req.wvalid & ~st_reg.w_held & ~st_reg.bvalid;
  assign ar_go = axi_req.arvalid & ~st_reg.rvalid;
  assign do_write = st_reg.aw_held & st_reg.w_held;

  // old value and legality of the held write address
  always_comb begin
    wr_old = '0;
    wr_ok = 1'b1;
    case (st_reg.aw_addr)
      OFF_CTRL: wr_old = 32'(st_reg.ctrl);
      OFF_EDGE: wr_old = 32'(st_reg.edgec);
      OFF_COUNT: wr_old = 32'(st_reg.cnt);
      OFF_CCA: wr_old = 32'(st_reg.cca);
      OFF_CCB: wr_old = 32'(st_reg.ccb);
      OFF_STAT: wr_old = '0;
      OFF_MASK: wr_old = 32'(st_reg.mask);
      default: wr_ok = 1'b0;
    endcase
    wr_val = tcc_wmerge(wr_old, st_reg.w_data, st_reg.w_strb);
  end

  // read mux; the counter reads live, no latching step needed
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    case (axi_req.araddr)
      OFF_CTRL: rd_val = 32'(st_reg.ctrl);
      OFF_EDGE: rd_val = 32'(st_reg.edgec);
      OFF_COUNT: rd_val = 32'(st_reg.cnt);
      OFF_CCA: rd_val = 32'(st_reg.cca);
      OFF_CCB: rd_val = 32'(st_reg.ccb);
      OFF_STAT: rd_val = 32'(st_reg.stat);
      OFF_MASK: rd_val = 32'(st_reg.mask);
      default: rd_ok = 1'b0;
    endcase
  end

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    st_next = st_reg;
    ev = '0;
    clr = '0;

    // bus write channels: address and data may come in either order
    if (aw_go) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (w_go) begin
      st_next.w_held = 1'b1;
      st_next.w_data = axi_req.wdata;
      st_next.w_strb = axi_req.wstrb;
    end
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      unique case (st_reg.aw_addr)
        OFF_CTRL: begin
          st_next.ctrl = tcc_ctrl_s'(wr_val[CTRL_W-1:0]);
          st_next.ctrl.rsvd = '0;
        end
        OFF_EDGE: st_next.edgec = tcc_edgec_s'(wr_val[EDGE_W-1:0]);
        OFF_CCA: st_next.cca = wr_val[CNT_W-1:0];
        OFF_CCB: st_next.ccb = wr_val[CNT_W-1:0];
        OFF_STAT: clr = wr_val[IRQ_W-1:0];
        OFF_MASK: st_next.mask = wr_val[IRQ_W-1:0];
        default: ;
      endcase
    end else if (st_reg.bvalid && axi_req.bready) begin
      st_next.bvalid = 1'b0;
    end

    // bus read channel, data taken from the mux on the address handshake edge
    if (ar_go) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_val;
      st_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.rvalid && axi_req.rready) begin
      st_next.rvalid = 1'b0;
    end

    // prescaler restarts whenever the timer is stopped
    if (st_reg.ctrl.mode == MODE_STOP || tick) begin
      st_next.presc_cnt = '0;
    end else begin
      st_next.presc_cnt = st_reg.presc_cnt + PRESC_ONE;
    end

    // up-counter; a trigger clear beats the count clock
    st_next.upd = tick;
    if (st_reg.ctrl.mode == MODE_CLR_TRIG && edge_a) begin
      st_next.cnt = CNT_ZERO;
    end else if (tick) begin
      if (st_reg.ctrl.mode == MODE_CLR_MATCH &&
          st_reg.cnt == st_reg.cca) begin
        st_next.cnt = CNT_ZERO;
      end else begin
        st_next.cnt = st_reg.cnt + CNT_ONE;
      end
    end

    // compare events fire once per new count value; no clear here
    st_next.match_a = st_reg.upd & ~st_reg.ctrl.a_capture &
                      (st_reg.cnt == st_reg.cca);
    st_next.match_b = st_reg.upd & ~st_reg.ctrl.b_capture &
                      (st_reg.cnt == st_reg.ccb);
    ev[IRQ_MATCH_A] = st_reg.match_a;
    ev[IRQ_MATCH_B] = st_reg.match_b;

    // captures overwrite a same-cycle software write
    if (a_cap_ev) begin
      st_next.cca = st_reg.cnt;
      ev[IRQ_CAP_A] = 1'b1;
    end
    if (b_cap_ev) begin
      st_next.ccb = st_reg.cnt;
      ev[IRQ_CAP_B] = 1'b1;
    end

    // sticky status: a new event wins over a write-one clear
    st_next.stat = (st_reg.stat & ~clr) | ev;

    // pulse high for counts 0..ccb of each 0..cca period
    st_next.tout = st_reg.ctrl.mode == MODE_CLR_MATCH && !trig_b_used &&
                   st_reg.cnt <= st_reg.ccb;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign axi_rsp.awready = ~st_reg.aw_held & ~st_reg.bvalid;
  assign axi_rsp.wready = ~st_reg.w_held & ~st_reg.bvalid;
  assign axi_rsp.bvalid = st_reg.bvalid;
  assign axi_rsp.bresp = st_reg.bresp;
  assign axi_rsp.arready = ~st_reg.rvalid;
  assign axi_rsp.rvalid = st_reg.rvalid;
  assign axi_rsp.rdata = st_reg.rdata;
  assign axi_rsp.rresp = st_reg.rresp;

  // pin released outside pulse mode and while trigger b is in use
  assign timer_output_pin = st_reg.tout;
  assign timer_output_en_n = st_reg.ctrl.mode != MODE_CLR_MATCH ||
                             trig_b_used;
  assign match_a_irq = st_reg.match_a;
  assign match_b_irq = st_reg.match_b;
  assign irq = |(st_reg.stat & st_reg.mask);

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_match_a_irq: assert property (
    st_reg.upd && !st_reg.ctrl.a_capture && st_reg.cnt == st_reg.cca
    |=> match_a_irq ##1 st_reg.stat[IRQ_MATCH_A])
    else $error("match on register a gave no interrupt");

  a_match_keeps_cnt: assert property (
    tick && st_reg.ctrl.mode == MODE_FREE && st_reg.cnt == st_reg.cca
    |=> st_reg.cnt == $past(st_reg.cnt) + CNT_ONE)
    else $error("compare match disturbed the free-running count");

  a_match_b_irq: assert property (
    st_reg.upd && !st_reg.ctrl.b_capture && st_reg.cnt == st_reg.ccb
    |=> match_b_irq ##1 st_reg.stat[IRQ_MATCH_B])
    else $error("match on register b gave no interrupt");

  a_cap_a_value: assert property (
    a_cap_ev |=> st_reg.cca == $past(st_reg.cnt) && st_reg.stat[IRQ_CAP_A])
    else $error("register a did not capture the count");

  a_tout_released: assert property (
    trig_b_used |-> timer_output_en_n ##1 !timer_output_pin)
    else $error("timer output driven while trigger b is in use");

  a_cap_b_value: assert property (
    b_cap_ev |=> st_reg.ccb == $past(st_reg.cnt))
    else $error("register b did not capture the count");

  a_period_wrap: assert property (
    tick && st_reg.ctrl.mode == MODE_CLR_MATCH && st_reg.cnt == st_reg.cca
    |=> st_reg.cnt == CNT_ZERO)
    else $error("count did not restart after matching register a");

  a_pulse_width: assert property (
    st_reg.ctrl.mode == MODE_CLR_MATCH && !trig_b_used
    |=> timer_output_pin == ($past(st_reg.cnt) <= $past(st_reg.ccb)))
    else $error("pulse level disagrees with register b");

  a_read_count: assert property (
    ar_go && axi_req.araddr == OFF_COUNT
    |=> axi_rsp.rvalid && axi_rsp.rdata == 32'($past(st_reg.cnt)))
    else $error("counter read did not return the live count");

endmodule

`default_nettype wire

// ===== hw/tcc_pkg.sv
// constants, types and helpers shared by the capture/compare timer
//
// Contract
// - a compare match on register a raises match_a and leaves the count, except in mode 11.
// - a compare match on register b raises match_b and leaves the count.
// - register a as capture latches the count on an edge of a or b.
// - while trigger b edges feed a capture, the timer output is not driven.
// - register b as capture latches the count on a trigger a edge.
// - mode 11 clears on a match with register a and drives a pulse train.
// - the pulse period is register a plus one count clocks.
// - the pulse is high for register b plus one count clocks per period.
// - reading the counter register returns the live count.
// - edge select 11 detects both rising and falling trigger edges.
`default_nettype none

package tcc_pkg;

  // ********************************************************
  // widths and register offsets
  // ********************************************************
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 3;
  localparam int IRQ_W = 4;
  localparam int CTRL_W = 7;
  localparam int EDGE_W = 6;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EDGE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CCA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CCB = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h18;

  // status and mask bit positions
  localparam int IRQ_MATCH_A = 0;
  localparam int IRQ_MATCH_B = 1;
  localparam int IRQ_CAP_A = 2;
  localparam int IRQ_CAP_B = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 3'h1;

  // ********************************************************
  // modes and fields
  // ********************************************************
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_FREE = 2'b01,
    MODE_CLR_TRIG = 2'b10,
    MODE_CLR_MATCH = 2'b11
  } tcc_mode_e;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } tcc_edge_e;

  // timer_mode_ctrl: bits 3:2 op mode, 4 a capture, 5 a on trigger b,
  // 6 b capture; bits 1:0 read as zero
  typedef struct packed {
    logic b_capture;
    logic a_trig_sel;
    logic a_capture;
    tcc_mode_e mode;
    logic [1:0] rsvd;
  } tcc_ctrl_s;

  // edge_prescale_ctrl: bits 1:0 edge a, 3:2 edge b, 5:4 count clock
  typedef struct packed {
    logic [1:0] presc;
    tcc_edge_e edge_b;
    tcc_edge_e edge_a;
  } tcc_edgec_s;

  // ********************************************************
  // axi4-lite carriers
  // ********************************************************
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } tcc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcc_axi_rsp_s;

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] tcc_wmerge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // last prescaler count before a count clock: divide by 1, 2, 4 or 8
  function automatic logic [PRESC_W-1:0] tcc_presc_last(input logic [1:0] p);
    return PRESC_W'((PRESC_ONE << p) - PRESC_ONE);
  endfunction

endpackage

`default_nettype wire

// ===== hw/tcc_edge_sync.sv
// trigger pin synchroniser and valid-edge detector
`default_nettype none

module tcc_edge_sync
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pin,
  input wire tcc_edge_e edge_sel,
  output logic edge_pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } tcc_es_s;

  tcc_es_s st_reg;
  tcc_es_s st_next;

  // ********************************************************
  // sync chain and edge decode
  // ********************************************************
  // meta is read only by sync, so no decision sees a metastable level
  always_comb begin
    st_next = st_reg;
    st_next.meta = pin;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
    unique case (edge_sel)
      EDGE_FALL: st_next.pulse = st_reg.prev & ~st_reg.sync;
      EDGE_RISE: st_next.pulse = ~st_reg.prev & st_reg.sync;
      EDGE_NONE: st_next.pulse = 1'b0;
      EDGE_BOTH: st_next.pulse = st_reg.prev ^ st_reg.sync;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign edge_pulse = st_reg.pulse;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_both_edges: assert property (
    edge_sel == EDGE_BOTH && st_reg.sync != st_reg.prev |=> edge_pulse)
    else $error("both-edge select missed an edge");

  a_sync_rise: assert property (
    edge_sel == EDGE_RISE && $rose(pin) ##1 pin ##1 pin &&
    edge_sel == EDGE_RISE |=> edge_pulse)
    else $error("rising edge not seen three cycles after the pin");

endmodule

`default_nettype wire

// ===== tb/tcc_pins.sv
// far-side model: trigger pin drivers and timer output pin observer
`default_nettype none

module tcc_pins
  import tcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic timer_output_pin,
  input wire logic timer_output_en_n,
  output logic trigger_input_a,
  output logic trigger_input_b,
  output logic pin_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_level = 1'b0;

  // pins idle low from time zero
  initial begin
    trigger_input_a = 1'b0;
    trigger_input_b = 1'b0;
  end

  // remember the last level the block really drove
  always @(posedge core_clk) begin
    if (!timer_output_en_n) begin
      last_level <= timer_output_pin;
    end
  end

  // a released pin shows the inverse, so a stale level never passes
  assign pin_seen = timer_output_en_n ? ~last_level : timer_output_pin;

  // each flip holds for many cycles, well above the synchroniser depth
  task automatic flip_a();
    @(posedge core_clk);
    trigger_input_a <= ~trigger_input_a;
  endtask

  task automatic flip_b();
    @(posedge core_clk);
    trigger_input_b <= ~trigger_input_b;
  endtask
endmodule

`default_nettype wire

// ===== tb/timer16_capture_compare_ppg_tb.sv
// register-level testbench of the capture/compare timer
`default_nettype none

module timer16_capture_compare_ppg_tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  tcc_axi_req_s req = '0;
  tcc_axi_rsp_s rsp;
  logic trig_a, trig_b, pin, en_n, mai, mbi, irq, pin_seen;
  logic [1:0] resp;
  logic [31:0] rd, c1, c2;
  int fail_count = 0;
  int n_checks = 0;
  int p, h, n;
  logic prev, cur;

  always #2 core_clk = ~core_clk;

  tcc_timer u_dut (.core_clk(core_clk), .nrst(nrst), .axi_req(req),
    .axi_rsp(rsp), .trigger_input_a(trig_a), .trigger_input_b(trig_b),
    .timer_output_pin(pin), .timer_output_en_n(en_n),
    .match_a_irq(mai), .match_b_irq(mbi), .irq(irq));

  tcc_pins u_pins (.core_clk(core_clk), .timer_output_pin(pin),
    .timer_output_en_n(en_n), .trigger_input_a(trig_a),
    .trigger_input_b(trig_b), .pin_seen(pin_seen));

  // ********************************************************
  // report and compare
  // ********************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout();
    fail_count++;
    test_done();
  endtask

  // ********************************************************
  // axi4-lite master
  // ********************************************************
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        req.bready <= 1'b0;
        resp = rsp.bresp;
        break;
      end
    end
    if (k == 50) timeout();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    d = '0;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        req.rready <= 1'b0;
        d = rsp.rdata;
        resp = rsp.rresp;
        break;
      end
    end
    if (k == 50) timeout();
  endtask

  // bounded wait for a match pulse, looked at in its only cycle
  task automatic wait_match(input logic sel_b);
    int k;
    for (k = 0; k < 500; k++) begin
      @(posedge core_clk);
      if (!sel_b && mai === 1'b1) break;
      if (sel_b && mbi === 1'b1) break;
    end
    if (k == 500) timeout();
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    // reset values, then an unmapped word
    axi_rd(OFF_CTRL, rd);
    chk(rd, 32'h0);
    axi_rd(OFF_COUNT, rd);
    chk(rd, 32'h0);
    axi_rd(8'h1c, rd);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h0);
    axi_wr(8'h1c, 32'h1);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    // pulse train from a stopped zero count: period 10, high 4
    axi_wr(OFF_CCA, 32'h9);
    axi_wr(OFF_CCB, 32'h3);
    axi_wr(OFF_CTRL, 32'h0c);
    chk({31'h0, en_n}, 32'h0);
    prev = pin_seen;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      cur = pin_seen;
      if (!prev && cur) break;
      prev = cur;
    end
    if (n == 100) timeout();
    p = 1;
    h = 1;
    for (n = 0; n < 100; n++) begin
      prev = cur;
      @(posedge core_clk);
      cur = pin_seen;
      if (!prev && cur) break;
      p++;
      if (cur) h++;
    end
    if (n == 100) timeout();
    chk(32'(p), 32'ha);
    chk(32'(h), 32'h4);
    axi_rd(OFF_COUNT, rd);
    chk({31'h0, rd <= 32'h9}, 32'h1);
    // free run with both compares; only match a reaches irq
    axi_wr(OFF_CCA, 32'h30);
    axi_wr(OFF_CCB, 32'h40);
    axi_wr(OFF_MASK, 32'h1);
    axi_wr(OFF_CTRL, 32'h04);
    // drop matches left over from the pulse phase so irq means a new one
    axi_wr(OFF_STAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    axi_rd(OFF_COUNT, c1);
    axi_rd(OFF_COUNT, c2);
    chk({31'h0, c2 > c1}, 32'h1);
    wait_match(1'b0);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    axi_rd(OFF_COUNT, rd);
    chk({31'h0, rd > 32'h30}, 32'h1);
    wait_match(1'b1);
    axi_rd(OFF_COUNT, rd);
    chk({31'h0, rd > 32'h40}, 32'h1);
    axi_rd(OFF_STAT, rd);
    chk(rd & 32'h3, 32'h3);
    axi_wr(OFF_STAT, 32'h3);
    axi_rd(OFF_STAT, rd);
    chk(rd & 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // both registers capture on trigger a, both edges
    axi_wr(OFF_EDGE, 32'h0f);
    axi_wr(OFF_CTRL, 32'h54);
    u_pins.flip_a();
    repeat (8) @(posedge core_clk);
    axi_rd(OFF_CCA, c1);
    axi_rd(OFF_CCB, rd);
    chk(rd, c1);
    chk({31'h0, c1 != 32'h0}, 32'h1);
    axi_rd(OFF_STAT, rd);
    chk(rd & 32'hc, 32'hc);
    axi_wr(OFF_STAT, 32'hc);
    u_pins.flip_a();
    repeat (8) @(posedge core_clk);
    axi_rd(OFF_CCA, c2);
    chk({31'h0, c2 != c1}, 32'h1);
    axi_rd(OFF_STAT, rd);
    chk(rd & 32'hc, 32'hc);
    chk({31'h0, irq}, 32'h0);
    // register a on trigger b in pulse mode: output must stay released
    axi_wr(OFF_CTRL, 32'h3c);
    repeat (2) @(posedge core_clk);
    chk({31'h0, en_n}, 32'h1);
    axi_wr(OFF_STAT, 32'hf);
    u_pins.flip_b();
    repeat (8) @(posedge core_clk);
    chk({31'h0, en_n}, 32'h1);
    axi_rd(OFF_STAT, rd);
    chk(rd & 32'hc, 32'h4);
    // clear on a rising trigger a edge, then count clock divided by eight
    axi_wr(OFF_EDGE, 32'h01);
    axi_wr(OFF_CTRL, 32'h08);
    u_pins.flip_a();
    repeat (8) @(posedge core_clk);
    axi_rd(OFF_COUNT, rd);
    chk({31'h0, rd < 32'h8}, 32'h1);
    axi_wr(OFF_EDGE, 32'h31);
    axi_rd(OFF_COUNT, c1);
    repeat (80) @(posedge core_clk);
    axi_rd(OFF_COUNT, c2);
    chk((c2 - c1) >> 1, 32'h5);
    // a falling edge must not clear while rising edges are selected
    u_pins.flip_a();
    repeat (8) @(posedge core_clk);
    axi_rd(OFF_COUNT, rd);
    chk({31'h0, rd >= c2}, 32'h1);
    test_done();
  end
endmodule

`default_nettype wire
